/* File: rtl/eeprom_emu_pkg.sv */
// constants, field layouts and carrier types of the emulated eeprom controller
// assumes a single 50 MHz bus clock and an Avalon-MM master on the register side
package eeprom_emu_pkg;
	// ==========================================================
	// array geometry
	localparam int ROWS = 1024;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [9:0] PROT_ROW = 10'h3fe;
	localparam logic [11:0] ARRAY_TOP = 12'h0800;
	// ==========================================================
	// register indices, byte address is 0x1000 plus four times the index
	localparam logic [3:0] IDX_CLKDIV = 4'h0;
	localparam logic [3:0] IDX_TEST_A = 4'h1;
	localparam logic [3:0] IDX_TEST_B = 4'h2;
	localparam logic [3:0] IDX_IRQCFG = 4'h3;
	localparam logic [3:0] IDX_PROT = 4'h4;
	localparam logic [3:0] IDX_STATUS = 4'h5;
	localparam logic [3:0] IDX_CMD = 4'h6;
	localparam logic [3:0] IDX_TEST_C = 4'h7;
	localparam logic [3:0] IDX_ADDR_HI = 4'h8;
	localparam logic [3:0] IDX_ADDR_LO = 4'h9;
	localparam logic [3:0] IDX_DATA_HI = 4'ha;
	localparam logic [3:0] IDX_DATA_LO = 4'hb;
	localparam int REG_SEL_BIT = 12;
	// ==========================================================
	// field positions and command codes
	localparam int PROT_GLOBAL_BIT = 7;
	localparam int PROT_SECTOR_OFF_BIT = 3;
	localparam int STAT_LAUNCH_BIT = 7;
	localparam int STAT_VIOL_BIT = 5;
	localparam int STAT_ACCERR_BIT = 4;
	localparam logic [7:0] CMD_READ_MASK = 8'h65;
	localparam logic [7:0] CMD_VERIFY = 8'h05;
	localparam logic [7:0] CMD_PROGRAM = 8'h20;
	localparam logic [7:0] CMD_SECTOR = 8'h40;
	localparam logic [7:0] CMD_MASS = 8'h41;
	// ==========================================================
	// carrier and state types
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} ctrl_state_type;
	typedef struct packed {
		logic read;
		logic write;
		logic [12:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} avs_req_type;
	typedef struct packed {
		logic [ROWS-1:0][15:0] mem;
		ctrl_state_type state;
		logic loaded;
		logic prescale_by_eight;
		logic [5:0] timing_divider_value;
		logic cmd_buffer_empty_irq_en;
		logic cmd_complete_irq_en;
		logic [7:0] write_protection;
		logic cmd_buffer_empty_flag;
		logic cmd_complete_flag;
		logic prot_violation;
		logic access_error;
		logic verify_blank;
		logic [7:0] command_code;
		logic [10:0] target_address;
		logic [15:0] write_data;
		logic [1:0] seq;
		logic [7:0] op;
		logic [10:0] op_addr;
		logic [15:0] op_data;
		logic [9:0] tcnt;
		logic [15:0] ticks;
		logic ack;
		logic wt;
		logic mis;
		logic [7:0] mis_byte;
		logic [31:0] rdata;
		logic irq;
	} state_type;
endpackage : eeprom_emu_pkg

/* File: rtl/eeprom_emulation_ctrl.sv */
// command-driven controller of a 2 Kbyte emulated eeprom, array held in flip-flops
// assumes a synchronous Avalon-MM master on clk_sys_i; nothing leaves the chip
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module eeprom_emulation_ctrl #(
	parameter logic [15:0] PROG_TICKS = 16'h0008,
	parameter logic [15:0] ERASE_TICKS = 16'h0020
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire eeprom_emu_pkg::avs_req_type avs_req_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o
);
	import eeprom_emu_pkg::*;

	// ==========================================================
	// state and address helpers
	state_type st_q;
	state_type st_d;
	logic [3:0] idx;
	logic reg_ok;
	logic [10:0] arr_a;
	logic [10:0] arr_b;
	logic [15:0] row_a;
	logic [15:0] row_b;
	logic [6:0] div_p1;
	logic [9:0] tick_total;
	logic [9:0] prot_size;
	logic [11:0] prot_base;
	logic global_hit;
	logic sector_hit;
	logic any_prot;
	logic take;
	logic mis_rd;
	logic finish;
	logic [7:0] wb;

	// the whole module interface lives on-chip
	assign idx = avs_req_i.address[5:2];
	assign reg_ok = (avs_req_i.address[11:6] == 6'h00) && (idx <= IDX_DATA_LO);
	assign arr_a = avs_req_i.address[10:0];
	assign arr_b = arr_a + 11'h001;
	assign row_a = st_q.mem[arr_a[10:1]];
	assign row_b = st_q.mem[arr_b[10:1]];
	assign wb = avs_req_i.writedata[7:0];
	assign mis_rd = arr_a[0] && (avs_req_i.byteenable[1:0] == 2'b11);
	assign take = (avs_req_i.read || avs_req_i.write) && !st_q.ack && !st_q.mis
		&& (st_q.state != ST_LOAD);

	// timing tick period in bus clocks; the prescaler multiplies by eight
	assign div_p1 = {1'b0, st_q.timing_divider_value} + 7'h01;
	assign tick_total = st_q.prescale_by_eight ? {div_p1, 3'b000} : {3'b000, div_p1};

	// protected sector grows downward from the top in 64 byte steps
	assign prot_size = {{1'b0, st_q.write_protection[2:0]} + 4'h1, 6'h00};
	assign prot_base = ARRAY_TOP - {2'b00, prot_size};
	assign global_hit = !st_q.write_protection[PROT_GLOBAL_BIT];
	assign sector_hit = !st_q.write_protection[PROT_SECTOR_OFF_BIT]
		&& ({1'b0, st_q.target_address} >= prot_base);
	assign any_prot = global_hit || !st_q.write_protection[PROT_SECTOR_OFF_BIT];
	assign finish = (st_q.state == ST_BUSY) && (st_q.tcnt == 10'h000)
		&& (st_q.ticks == 16'h0000);

	// ==========================================================
	// next-state logic: bus slave first, array engine after, so events win
	always_comb begin
		st_d = st_q;
		st_d.wt = 1'b1;
		st_d.ack = 1'b0;
		if (st_q.state == ST_LOAD) begin
			st_d.write_protection = st_q.mem[PROT_ROW][7:0];
			st_d.state = ST_IDLE;
		end else if (st_q.mis && !st_q.ack) begin
			// second half of a misaligned word read
			st_d.rdata = (st_q.state == ST_BUSY) ? 32'h0000_0000 :
				{16'h0000, st_q.mis_byte, row_b[15:8]};
			st_d.mis = 1'b0;
			st_d.wt = 1'b0;
			st_d.ack = 1'b1;
		end else if (take && avs_req_i.read) begin
			st_d.rdata = 32'h0000_0000;
			st_d.wt = 1'b0;
			st_d.ack = 1'b1;
			if (avs_req_i.address[REG_SEL_BIT]) begin
				// status stays readable during an operation
				if (reg_ok) begin
					case (idx)
						IDX_CLKDIV: st_d.rdata[7:0] = {st_q.loaded, st_q.prescale_by_eight,
							st_q.timing_divider_value};
						IDX_IRQCFG: st_d.rdata[7:0] = {st_q.cmd_buffer_empty_irq_en,
							st_q.cmd_complete_irq_en, 6'h00};
						IDX_PROT: st_d.rdata[7:0] = st_q.write_protection;
						IDX_STATUS: st_d.rdata[7:0] = {st_q.cmd_buffer_empty_flag,
							st_q.cmd_complete_flag, st_q.prot_violation, st_q.access_error,
							1'b0, st_q.verify_blank, 2'b00};
						IDX_CMD: st_d.rdata[7:0] = st_q.command_code & CMD_READ_MASK;
						IDX_ADDR_HI: st_d.rdata[7:0] = {5'h00, st_q.target_address[10:8]};
						IDX_ADDR_LO: st_d.rdata[7:0] = st_q.target_address[7:0];
						IDX_DATA_HI: st_d.rdata[7:0] = st_q.write_data[15:8];
						IDX_DATA_LO: st_d.rdata[7:0] = st_q.write_data[7:0];
						default: st_d.rdata[7:0] = 8'h00;
					endcase
				end
			end else if (avs_req_i.address[11] || st_q.state == ST_BUSY) begin
				st_d.rdata = 32'h0000_0000;
			end else if (mis_rd) begin
				// hold the bus one more cycle for the neighbouring row
				st_d.mis = 1'b1;
				st_d.mis_byte = row_a[7:0];
				st_d.wt = 1'b1;
				st_d.ack = 1'b0;
			end else if (avs_req_i.byteenable[1:0] == 2'b11) begin
				st_d.rdata[15:0] = row_a;
			end else begin
				st_d.rdata[7:0] = arr_a[0] ? row_a[7:0] : row_a[15:8];
			end
		end else if (take && avs_req_i.write) begin
			st_d.wt = 1'b0;
			st_d.ack = 1'b1;
			if (!avs_req_i.address[REG_SEL_BIT]) begin
				// first step: array write latches address and data
				if (!st_q.loaded || st_q.access_error || st_q.prot_violation
					|| st_q.seq != 2'b00 || arr_a[0] || avs_req_i.address[11]
					|| avs_req_i.byteenable[1:0] != 2'b11) begin
					st_d.access_error = 1'b1;
					st_d.seq = 2'b00;
				end else begin
					st_d.target_address = arr_a;
					st_d.write_data = avs_req_i.writedata[15:0];
					st_d.seq = 2'b01;
				end
			end else if (reg_ok && avs_req_i.byteenable[0]) begin
				case (idx)
					IDX_CLKDIV: begin
						// divider is write-once; later writes are dropped
						if (!st_q.loaded) begin
							st_d.loaded = 1'b1;
							st_d.prescale_by_eight = wb[6];
							st_d.timing_divider_value = wb[5:0];
						end
					end
					IDX_IRQCFG: begin
						st_d.cmd_buffer_empty_irq_en = wb[7];
						st_d.cmd_complete_irq_en = wb[6];
					end
					IDX_PROT: begin
						// protect bits only move toward protecting, size while sector off
						st_d.write_protection[7] = st_q.write_protection[7] & wb[7];
						st_d.write_protection[3] = st_q.write_protection[3] & wb[3];
						if (st_q.write_protection[3]) begin
							st_d.write_protection[2:0] = wb[2:0];
						end
					end
					IDX_CMD: begin
						// second step: command, checked against protection
						if (st_q.seq != 2'b01) begin
							st_d.access_error = 1'b1;
							st_d.seq = 2'b00;
						end else if (!(wb inside {CMD_VERIFY, CMD_PROGRAM, CMD_SECTOR,
							CMD_MASS})) begin
							st_d.access_error = 1'b1;
							st_d.seq = 2'b00;
						end else if ((wb == CMD_MASS && any_prot)
							|| ((wb == CMD_PROGRAM || wb == CMD_SECTOR)
							&& (global_hit || sector_hit))) begin
							st_d.prot_violation = 1'b1;
							st_d.seq = 2'b00;
						end else begin
							st_d.command_code = wb;
							st_d.seq = 2'b10;
						end
					end
					IDX_STATUS: begin
						if (wb[STAT_VIOL_BIT]) begin
							st_d.prot_violation = 1'b0;
						end
						if (wb[STAT_ACCERR_BIT]) begin
							st_d.access_error = 1'b0;
						end
						// third step: writing one to the buffer flag launches
						if (wb[STAT_LAUNCH_BIT] && st_q.seq == 2'b10) begin
							if (st_q.state == ST_BUSY) begin
								st_d.access_error = 1'b1;
							end else begin
								st_d.state = ST_BUSY;
								st_d.op = st_q.command_code;
								st_d.op_addr = st_q.target_address;
								st_d.op_data = st_q.write_data;
								st_d.tcnt = tick_total - 10'h001;
								st_d.cmd_complete_flag = 1'b0;
								st_d.verify_blank = 1'b0;
								case (st_q.command_code)
									CMD_PROGRAM: st_d.ticks = PROG_TICKS - 16'h0001;
									CMD_VERIFY: st_d.ticks = 16'h0000;
									default: st_d.ticks = ERASE_TICKS - 16'h0001;
								endcase
							end
							st_d.seq = 2'b00;
						end else if (!wb[STAT_LAUNCH_BIT] && st_q.seq != 2'b00) begin
							st_d.access_error = 1'b1;
							st_d.seq = 2'b00;
						end
					end
					IDX_ADDR_HI: st_d.target_address[10:8] = wb[2:0];
					IDX_ADDR_LO: st_d.target_address[7:0] = wb;
					IDX_DATA_HI: st_d.write_data[15:8] = wb;
					IDX_DATA_LO: st_d.write_data[7:0] = wb;
					default: st_d.seq = st_q.seq;
				endcase
			end
		end
		// array engine: count timing ticks, then apply the operation
		if (st_q.state == ST_BUSY) begin
			if (st_q.tcnt != 10'h000) begin
				st_d.tcnt = st_q.tcnt - 10'h001;
			end else if (!finish) begin
				st_d.tcnt = tick_total - 10'h001;
				st_d.ticks = st_q.ticks - 16'h0001;
			end else begin
				case (st_q.op)
					CMD_PROGRAM: st_d.mem[st_q.op_addr[10:1]] =
						st_q.mem[st_q.op_addr[10:1]] & st_q.op_data;
					CMD_SECTOR: begin
						st_d.mem[{st_q.op_addr[10:2], 1'b0}] = ERASED_WORD;
						st_d.mem[{st_q.op_addr[10:2], 1'b1}] = ERASED_WORD;
					end
					CMD_MASS: st_d.mem = {ROWS{ERASED_WORD}};
					default: st_d.verify_blank = &st_q.mem;
				endcase
				st_d.cmd_complete_flag = 1'b1;
				st_d.state = ST_IDLE;
			end
		end
		// buffer is handed to the engine at launch, so it reads empty at once
		st_d.cmd_buffer_empty_flag = 1'b1;
		st_d.irq = (st_d.cmd_buffer_empty_flag & st_d.cmd_buffer_empty_irq_en)
			| (st_d.cmd_complete_flag & st_d.cmd_complete_irq_en);
	end

	// ==========================================================
	// state register; the array comes up erased since it is emulated in flops
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_q <= '0;
			st_q.mem <= {ROWS{ERASED_WORD}};
			st_q.state <= ST_LOAD;
			st_q.cmd_buffer_empty_flag <= 1'b1;
			st_q.cmd_complete_flag <= 1'b1;
			st_q.wt <= 1'b1;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end

	assign avs_readdata_o = st_q.rdata;
	assign avs_waitrequest_o = st_q.wt;
	assign irq_o = st_q.irq;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i || !ce_i);

	property p_reserved_zero;
		take && avs_req_i.read && avs_req_i.address[REG_SEL_BIT]
			&& (idx == IDX_TEST_A || idx == IDX_TEST_B || idx == IDX_TEST_C)
			|=> !avs_waitrequest_o && avs_readdata_o == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("test reg not zero");

	property p_unmapped_zero;
		take && avs_req_i.read && avs_req_i.address[REG_SEL_BIT] && !reg_ok
			|=> avs_readdata_o == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");

	property p_aligned_one;
		take && avs_req_i.read && !avs_req_i.address[REG_SEL_BIT] && !mis_rd
			|=> !avs_waitrequest_o;
	endproperty
	a_aligned_one: assert property (p_aligned_one) else $error("aligned read slow");

	property p_mis_two;
		take && avs_req_i.read && !avs_req_i.address[REG_SEL_BIT] && mis_rd
			&& !avs_req_i.address[11] && st_q.state != ST_BUSY
			|=> avs_waitrequest_o ##1 !avs_waitrequest_o;
	endproperty
	a_mis_two: assert property (p_mis_two) else $error("misaligned timing");

	property p_busy_read;
		take && avs_req_i.read && !avs_req_i.address[REG_SEL_BIT] && st_q.state == ST_BUSY
			|=> avs_readdata_o == 32'h0000_0000;
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("data while busy");

	property p_poll_busy;
		take && avs_req_i.address[REG_SEL_BIT] && st_q.state == ST_BUSY |=> !avs_waitrequest_o;
	endproperty
	a_poll_busy: assert property (p_poll_busy) else $error("poll stalled");

	property p_global;
		take && avs_req_i.write && avs_req_i.address[REG_SEL_BIT] && idx == IDX_CMD && reg_ok
			&& avs_req_i.byteenable[0] && st_q.seq == 2'b01 && global_hit && wb == CMD_PROGRAM
			|=> st_q.prot_violation && st_q.seq == 2'b00;
	endproperty
	a_global: assert property (p_global) else $error("global protect missed");

	property p_sector;
		take && avs_req_i.write && avs_req_i.address[REG_SEL_BIT] && idx == IDX_CMD && reg_ok
			&& avs_req_i.byteenable[0] && st_q.seq == 2'b01 && sector_hit
			&& (wb == CMD_PROGRAM || wb == CMD_SECTOR) |=> st_q.prot_violation;
	endproperty
	a_sector: assert property (p_sector) else $error("sector protect missed");

	property p_mass;
		finish && st_q.op == CMD_MASS
			|=> st_q.mem[0] == ERASED_WORD && st_q.mem[ROWS-1] == ERASED_WORD;
	endproperty
	a_mass: assert property (p_mass) else $error("mass erase incomplete");

	property p_sect_rows;
		finish && st_q.op == CMD_SECTOR
			|=> st_q.mem[{st_q.op_addr[10:2], 1'b1}] == ERASED_WORD && st_q.cmd_complete_flag;
	endproperty
	a_sect_rows: assert property (p_sect_rows) else $error("sector erase wrong");

	property p_prog_zero;
		finish && st_q.op == CMD_PROGRAM
			|=> (st_q.mem[st_q.op_addr[10:1]] & ~st_q.op_data) == 16'h0000;
	endproperty
	a_prog_zero: assert property (p_prog_zero) else $error("program did not clear");

	property p_load;
		st_q.state == ST_LOAD |=> st_q.write_protection == st_q.mem[PROT_ROW][7:0];
	endproperty
	a_load: assert property (p_load) else $error("protection not loaded");

	property p_irq;
		st_q.cmd_complete_flag && st_q.cmd_complete_irq_en |-> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("complete irq missing");

	property p_irq_cause;
		irq_o |-> (st_q.cmd_buffer_empty_flag && st_q.cmd_buffer_empty_irq_en)
			|| (st_q.cmd_complete_flag && st_q.cmd_complete_irq_en);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

	c_program: cover property (finish && st_q.op == CMD_PROGRAM);
	c_mass: cover property (finish && st_q.op == CMD_MASS);
	c_mis: cover property (st_q.mis ##1 !avs_waitrequest_o);
	c_viol: cover property ($rose(st_q.prot_violation));
endmodule : eeprom_emulation_ctrl
`default_nettype wire

/* File: verif/cpu_bus_model.sv */
// stand-in for the cpu core: an avalon-mm master doing one access at a time
// assumes waitrequest and readdata come out of registers in the slave
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
	input wire logic clk_sys_i,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i,
	output var eeprom_emu_pkg::avs_req_type req_o
);
	import eeprom_emu_pkg::*;
	initial req_o = '0;
	// ==========================================================
	// one access, request held until waitrequest is seen low at an edge
	task automatic access(input logic wr, input logic [12:0] addr, input logic [31:0] wdata,
		input logic [3:0] be, output logic [31:0] rdata, output logic ok);
		ok = 1'b0;
		rdata = '0;
		@(posedge clk_sys_i);
		req_o <= '{read: !wr, write: wr, address: addr, writedata: wdata, byteenable: be};
		// waitrequest is read at the rising edge, before the slave's own update lands
		for (int i = 0; i < 64 && !ok; i++) begin
			@(posedge clk_sys_i);
			if (avs_waitrequest_i === 1'b0) begin
				ok = 1'b1;
				rdata = avs_readdata_i;
			end
		end
		// released right after the answering edge; junk so a stale value never passes
		req_o <= '{read: 1'b0, write: 1'b0, address: ~addr, writedata: ~wdata, byteenable: ~be};
	endtask : access
endmodule : cpu_bus_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench of the emulated eeprom controller
// assumes the cpu_bus_model master and the controller's default tick counts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import eeprom_emu_pkg::*;
	typedef struct {
		logic [12:0] addr;
		logic [31:0] exp;
		logic [31:0] mask;
	} note_type;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce = 1'b1;
	avs_req_type req;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic [31:0] last_rd;
	logic [10:0] base;
	logic [15:0] d0, d1, d2;
	note_type notes[$];
	note_type cur;
	int bad_count = 0;
	int checked = 0;
	// ==========================================================
	// clock, design and bus master
	initial forever #10 clk_sys_i = ~clk_sys_i;
	eeprom_emulation_ctrl dut_u (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.ce_i(ce),
		.avs_req_i(req),
		.avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest),
		.irq_o(irq)
	);
	cpu_bus_model bus_u (
		.clk_sys_i(clk_sys_i),
		.avs_readdata_i(avs_readdata),
		.avs_waitrequest_i(avs_waitrequest),
		.req_o(req)
	);
	// ==========================================================
	// reporting
	task automatic finish_test();
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected 0x%h seen 0x%h", what, exp, seen);
		end
	endtask : check
	// answered reads are matched against the oldest note; mask zero means poll only
	always @(negedge clk_sys_i) begin
		if (req.read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (notes.size() == 0) check("read note", 32'h0000_0001, 32'h0000_0000);
			else begin
				cur = notes.pop_front();
				if (cur.mask != '0) check($sformatf("read 0x%h", cur.addr), cur.exp & cur.mask,
					avs_readdata & cur.mask);
			end
		end
	end
	// ==========================================================
	// bus helpers
	task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d,
		input logic [3:0] be, input logic [31:0] exp, input logic [31:0] mask);
		logic ok;
		if (!wr) notes.push_back('{a, exp, mask});
		bus_u.access(wr, a, d, be, last_rd, ok);
		if (!ok) begin
			check("waitrequest", 32'h0000_0000, 32'h0000_0001);
			finish_test();
		end
	endtask : bus
	task automatic wreg(input logic [3:0] idx, input logic [7:0] v);
		bus(1'b1, 13'h1000 + {7'h00, idx, 2'b00}, {24'h00_0000, v}, 4'h1, '0, '0);
	endtask : wreg
	task automatic rreg(input logic [3:0] idx, input logic [7:0] exp, input logic [7:0] mask);
		bus(1'b0, 13'h1000 + {7'h00, idx, 2'b00}, '0, 4'hf, {24'h00_0000, exp},
			{24'h00_0000, mask});
	endtask : rreg
	task automatic rarr(input logic [11:0] a, input logic [3:0] be, input logic [15:0] exp);
		bus(1'b0, {1'b0, a}, '0, be, {16'h0000, exp}, (be == 4'h3) ? 32'h0000_ffff : 32'h0000_00ff);
	endtask : rarr
	// three-step launch, then status is polled until the complete flag returns
	task automatic run_op(input logic [7:0] cmd, input logic [10:0] a, input logic [15:0] d,
		input logic busy_chk);
		int i;
		bus(1'b1, {2'b00, a}, {16'h0000, d}, 4'h3, '0, '0);
		wreg(IDX_CMD, cmd);
		wreg(IDX_STATUS, 8'h80);
		if (busy_chk) begin
			rarr({1'b0, a}, 4'h3, 16'h0000);
			rreg(IDX_STATUS, 8'h80, 8'hc0);
		end
		for (i = 0; i < 200; i++) begin
			rreg(IDX_STATUS, 8'h00, 8'h00);
			if (last_rd[6] === 1'b1) break;
		end
		if (i == 200) begin
			check("complete flag", 32'h0000_0001, 32'h0000_0000);
			finish_test();
		end
	endtask : run_op
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(61));
		base = 11'($urandom_range(0, 493) << 2);
		d0 = 16'($urandom());
		d1 = 16'($urandom());
		d2 = 16'($urandom());
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rreg(IDX_PROT, 8'hff, 8'hff);
		rreg(IDX_STATUS, 8'hc0, 8'hff);
		// reserved places ignore writes, unmapped offsets read zero
		wreg(IDX_TEST_A, 8'hff);
		wreg(IDX_TEST_B, 8'hff);
		wreg(IDX_TEST_C, 8'hff);
		rreg(IDX_TEST_A, 8'h00, 8'hff);
		rreg(IDX_TEST_B, 8'h00, 8'hff);
		rreg(IDX_TEST_C, 8'h00, 8'hff);
		for (int k = 12; k < 16; k++) rreg(4'(k), 8'h00, 8'hff);
		rarr(12'h800, 4'h3, 16'h0000);
		rarr(12'h7fe, 4'h3, ERASED_WORD);
		rarr({1'b0, base}, 4'h1, 16'h00ff);
		wreg(IDX_CLKDIV, 8'h00);
		// three words programmed once each, then byte and misaligned reads
		run_op(CMD_PROGRAM, base, d0, 1'b1);
		run_op(CMD_PROGRAM, base + 11'd2, d1, 1'b0);
		run_op(CMD_PROGRAM, base + 11'd4, d2, 1'b0);
		rreg(IDX_STATUS, 8'hc0, 8'hff);
		rarr({1'b0, base}, 4'h3, d0);
		rarr({1'b0, base}, 4'h1, {8'h00, d0[15:8]});
		rarr({1'b0, base} + 12'd1, 4'h3, {d0[7:0], d1[15:8]});
		// sector erase clears both rows of the sector only
		run_op(CMD_SECTOR, base, ERASED_WORD, 1'b1);
		rarr({1'b0, base}, 4'h3, ERASED_WORD);
		rarr({1'b0, base} + 12'd2, 4'h3, ERASED_WORD);
		rarr({1'b0, base} + 12'd4, 4'h3, d2);
		run_op(CMD_MASS, base, ERASED_WORD, 1'b1);
		rarr({1'b0, base} + 12'd4, 4'h3, ERASED_WORD);
		run_op(CMD_VERIFY, 11'h000, ERASED_WORD, 1'b0);
		rreg(IDX_STATUS, 8'hc4, 8'hff);
		// each flag reaches the interrupt only through its own enable
		wreg(IDX_IRQCFG, 8'h40);
		rreg(IDX_IRQCFG, 8'h40, 8'hff);
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check("irq complete", 32'h0000_0001, {31'h0, irq});
		wreg(IDX_IRQCFG, 8'h80);
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check("irq empty", 32'h0000_0001, {31'h0, irq});
		// a low clock enable freezes the interrupt and the idle bus answer
		@(posedge clk_sys_i);
		ce <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check("irq frozen", 32'h0000_0001, {31'h0, irq});
		check("wait frozen", 32'h0000_0001, {31'h0, avs_waitrequest});
		@(posedge clk_sys_i);
		ce <= 1'b1;
		wreg(IDX_IRQCFG, 8'h00);
		repeat (2) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check("irq off", 32'h0000_0000, {31'h0, irq});
		// smallest top sector protected, then the whole array
		wreg(IDX_PROT, 8'hf0);
		rreg(IDX_PROT, 8'hf0, 8'hff);
		run_op(CMD_PROGRAM, 11'h7c0, d0, 1'b0);
		rreg(IDX_STATUS, 8'h20, 8'h20);
		rarr(12'h7c0, 4'h3, ERASED_WORD);
		wreg(IDX_STATUS, 8'h30);
		rreg(IDX_STATUS, 8'h00, 8'h30);
		wreg(IDX_PROT, 8'h70);
		run_op(CMD_PROGRAM, base, d0, 1'b0);
		rreg(IDX_STATUS, 8'h20, 8'h20);
		rarr({1'b0, base}, 4'h3, ERASED_WORD);
		repeat (2) @(posedge clk_sys_i);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
